// ---- logic/swm_master.sv ----
`timescale 1ns/10ps
`default_nettype none
module swm_master
  import swm_pkg::*;
#(
  parameter int unsigned LONG_CYC    = LONG_PULSE_NS / CLK_NS,
  parameter int unsigned START_CYC   = START_PULSE_NS / CLK_NS,
  parameter int unsigned RESET_CYC   = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS,
  parameter int unsigned THR_OS_CYC  = THR_ONE_START_NS / CLK_NS,
  parameter int unsigned THR_SA_CYC  = THR_START_ATT_NS / CLK_NS,
  parameter int unsigned THR_AR_CYC  = THR_ATT_RST_NS / CLK_NS
)
(
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire swm_cmd_t cmd,
  input  wire logic     cmd_valid,
  output var  logic     cmd_ready,
  output var  swm_rsp_t rsp,
  output var  logic     rsp_valid,
  output var  logic     reset_event,
  output var  logic     bus_idle,
  input  wire logic     swd_in,
  output var  logic     swd_out,
  output var  logic     swd_oe
);
  localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] IDLE_C   = CNT_W'(IDLE_GAP_CYC);
  localparam logic [CNT_W-1:0] SHORT_C  = CNT_W'(SHORT_CYC);
  localparam logic [CNT_W-1:0] LONG_C   = CNT_W'(LONG_CYC);
  localparam logic [CNT_W-1:0] START_C  = CNT_W'(START_CYC);
  localparam logic [CNT_W-1:0] RESET_C  = CNT_W'(RESET_CYC);
  localparam logic [CNT_W-1:0] THR_ZO_C = CNT_W'(THR_ZO_CYC);
  localparam logic [CNT_W-1:0] THR_OS_C = CNT_W'(THR_OS_CYC);
  localparam logic [CNT_W-1:0] THR_SA_C = CNT_W'(THR_SA_CYC);
  localparam logic [CNT_W-1:0] THR_AR_C = CNT_W'(THR_AR_CYC);

  typedef struct packed {
    swm_state_t       st;
    logic [CNT_W-1:0] cnt;
    swm_kind_t        kind;
    logic             wbit;
    logic             own;
    logic             oe;
    logic             drv;
    logic             ready;
    logic             idle;
    swm_rsp_t         rsp;
    logic             rsp_valid;
    logic             rst_ev;
  } swm_mst_t;

  localparam swm_mst_t RESET_STATE = '{
    st:        SWM_S_RESET,
    cnt:       '0,
    kind:      SWM_K_RESET,
    wbit:      1'b0,
    own:       1'b1,
    oe:        1'b1,
    drv:       1'b0,
    ready:     1'b0,
    idle:      1'b0,
    rsp:       '0,
    rsp_valid: 1'b0,
    rst_ev:    1'b0
  };

  swm_mst_t s;
  swm_mst_t next_s;
  logic     line;

  swm_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     (swd_in),
    .dout    (line)
  );

  // Pulse width alone decides the symbol.
  function automatic swm_sym_t classify(input logic [CNT_W-1:0] c);
    swm_sym_t y;
    if (c < THR_ZO_C)
    begin
      y = SWM_Y_ZERO;
    end
    else if (c < THR_OS_C)
    begin
      y = SWM_Y_ONE;
    end
    else if (c < THR_SA_C)
    begin
      y = SWM_Y_START;
    end
    else if (c < THR_AR_C)
    begin
      y = SWM_Y_ATTN;
    end
    else
    begin
      y = SWM_Y_RST;
    end
    return y;
  endfunction : classify

  logic [CNT_W-1:0] width;
  swm_sym_t         sym;

  always_comb
  begin
    unique case (s.kind)
      SWM_K_WRITE: width = s.wbit ? LONG_C : SHORT_C;
      SWM_K_READ:  width = SHORT_C;
      SWM_K_START: width = START_C;
      SWM_K_RESET: width = RESET_C;
    endcase
  end

  assign sym = classify(s.cnt);

  always_comb
  begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    next_s.rst_ev = 1'b0;
    next_s.drv = 1'b0;
    if (s.cnt != CNT_MAX)
    begin
      next_s.cnt = s.cnt + CNT_ONE;
    end
    // A low that outlasts the attention range is a reset.
    if ((s.st != SWM_S_GAP) && (s.st != SWM_S_IDLE) && (s.cnt == THR_AR_C))
    begin
      next_s.rst_ev = 1'b1;
    end
    unique case (s.st)
      SWM_S_RESET:
      begin
        // Own reset pulse, held at least the least reset time.
        next_s.oe = 1'b1;
        if (s.cnt >= RESET_C)
        begin
          next_s.oe = 1'b0;
          next_s.st = SWM_S_LOW;
        end
      end
      SWM_S_GAP:
      begin
        if (line != LINE_HIGH)
        begin
          next_s.st = SWM_S_LOW;
          next_s.own = 1'b0;
          next_s.cnt = CNT_ONE;
        end
        else if (s.cnt >= IDLE_C)
        begin
          next_s.st = SWM_S_IDLE;
          next_s.idle = 1'b1;
          next_s.ready = 1'b1;
        end
      end
      SWM_S_IDLE:
      begin
        if (cmd_valid)
        begin
          // Drive only from the idle state; a command wins over a low seen in the same cycle.
          next_s.ready = 1'b0;
          next_s.idle = 1'b0;
          next_s.kind = cmd.kind;
          next_s.wbit = cmd.wbit;
          next_s.own = 1'b1;
          next_s.oe = 1'b1;
          next_s.cnt = '0;
          next_s.st = (cmd.kind == SWM_K_RESET) ? SWM_S_RESET : SWM_S_DRIVE;
        end
        else if (line != LINE_HIGH)
        begin
          // Someone else pulled low; time it.
          next_s.ready = 1'b0;
          next_s.idle = 1'b0;
          next_s.own = 1'b0;
          next_s.cnt = CNT_ONE;
          next_s.st = SWM_S_LOW;
        end
      end
      SWM_S_DRIVE:
      begin
        if (s.cnt >= width)
        begin
          next_s.oe = 1'b0;
          next_s.st = SWM_S_LOW;
        end
      end
      SWM_S_LOW:
      begin
        // The bit ends when the line is high again, not at release.
        if (line == LINE_HIGH)
        begin
          next_s.rsp.sym = sym;
          next_s.rsp.data = (sym == SWM_Y_ONE);
          next_s.rsp.own = s.own;
          next_s.rsp.collide = s.own && (s.kind != SWM_K_RESET) &&
                               ((sym == SWM_Y_ATTN) || (sym == SWM_Y_RST));
          next_s.rsp_valid = 1'b1;
          next_s.cnt = '0;
          next_s.st = SWM_S_GAP;
        end
      end
      default:
      begin
        next_s = RESET_STATE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s <= RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign cmd_ready   = s.ready;
  assign rsp         = s.rsp;
  assign rsp_valid   = s.rsp_valid;
  assign reset_event = s.rst_ev;
  assign bus_idle    = s.idle;
  assign swd_out     = s.drv;
  assign swd_oe      = s.oe;
endmodule : swm_master
`default_nettype wire

// ---- logic/swm_pkg.sv ----
`timescale 1ns/10ps
`default_nettype none
package swm_pkg;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned CLK_NS = 10;
  // Line timing in ns.
  localparam int unsigned IDLE_GAP_NS      = 11000;
  localparam int unsigned SHORT_PULSE_NS   = 14400;
  localparam int unsigned LONG_PULSE_NS    = 42000;
  localparam int unsigned START_PULSE_NS   = 94000;
  localparam int unsigned RESET_PULSE_NS   = 400000;
  localparam int unsigned THR_ZERO_ONE_NS  = 22000;
  localparam int unsigned THR_ONE_START_NS = 64000;
  localparam int unsigned THR_START_ATT_NS = 137000;
  localparam int unsigned THR_ATT_RST_NS   = 291000;
  // Least times round up to whole cycles.
  localparam int unsigned IDLE_GAP_CYC  = (IDLE_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SHORT_CYC     = (SHORT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned THR_ZO_CYC    = THR_ZERO_ONE_NS / CLK_NS;
  localparam logic        LINE_HIGH     = 1'b1;

  typedef enum logic [4:0] {
    SWM_S_RESET = 5'h01,
    SWM_S_GAP   = 5'h02,
    SWM_S_IDLE  = 5'h04,
    SWM_S_DRIVE = 5'h08,
    SWM_S_LOW   = 5'h10
  } swm_state_t;

  typedef enum logic [1:0] {
    SWM_K_WRITE = 2'h0,
    SWM_K_READ  = 2'h1,
    SWM_K_START = 2'h2,
    SWM_K_RESET = 2'h3
  } swm_kind_t;

  typedef enum logic [2:0] {
    SWM_Y_ZERO  = 3'h0,
    SWM_Y_ONE   = 3'h1,
    SWM_Y_START = 3'h2,
    SWM_Y_ATTN  = 3'h3,
    SWM_Y_RST   = 3'h4
  } swm_sym_t;

  typedef struct packed {
    swm_kind_t kind;
    logic      wbit;
  } swm_cmd_t;

  typedef struct packed {
    swm_sym_t sym;
    logic     data;
    logic     own;
    logic     collide;
  } swm_rsp_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } swm_sync_t;
endpackage : swm_pkg

module swm_sync
  import swm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);
  swm_sync_t s;
  swm_sync_t next_s;

  // A change counts once the second and third stages agree.
  always_comb
  begin
    next_s = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3)
    begin
      next_s.level = s.s3;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s <= {4{LINE_HIGH}};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dout = s.level;
endmodule : swm_sync
`default_nettype wire

// ---- testbench/swm_master_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module swm_master_chk
  import swm_pkg::*;
#(
  parameter int unsigned LONG_CYC = 4200, START_CYC = 9400,
  parameter int unsigned RESET_CYC = 40000, THR_OS_CYC = 6400,
  parameter int unsigned THR_SA_CYC = 13700, THR_AR_CYC = 29100
)
(
  input wire logic     sys_clk,
  input wire logic     rst,
  input wire swm_cmd_t cmd,
  input wire logic     cmd_valid,
  input wire logic     cmd_ready,
  input wire swm_rsp_t rsp,
  input wire logic     rsp_valid,
  input wire logic     reset_event,
  input wire logic     bus_idle,
  input wire logic     swd_in,
  input wire logic     swd_out,
  input wire logic     swd_oe
);
  logic [CNT_W-1:0] oe_cnt;
  logic [CNT_W-1:0] hi_cnt;
  logic [CNT_W-1:0] lo_cnt;
  always_ff @(posedge sys_clk)
  begin
    oe_cnt <= (rst || !swd_oe) ? '0 : oe_cnt + 1'b1;
    hi_cnt <= (rst || !swd_in) ? '0 : hi_cnt + 1'b1;
    lo_cnt <= (rst || swd_in) ? '0 : lo_cnt + 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_drive: assert property (disable iff (1'b0)
    rst |=> swd_oe && !cmd_ready) else $error("no reset drive");
  a_open_drain: assert property (
    swd_out == 1'b0) else $error("line driven high");
  a_ready_drop: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready && swd_oe) else $error("no take");
  a_busy_drive: assert property (
    swd_oe |-> !cmd_ready) else $error("ready while driving");
  a_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid) else $error("rsp_valid not a pulse");
  a_data_one: assert property (
    rsp_valid |-> rsp.data == (rsp.sym == SWM_Y_ONE)) else $error("data");
  a_rsp_high: assert property (
    rsp_valid |-> swd_in && $past(swd_in)) else $error("rsp while low");
  a_idle_gap: assert property (
    $rose(cmd_ready) |-> hi_cnt >= IDLE_GAP_CYC) else $error("gap short");
  a_pulse_width: assert property (
    $fell(swd_oe) |-> oe_cnt inside {[SHORT_CYC:SHORT_CYC+2],
      [LONG_CYC:LONG_CYC+2], [START_CYC:START_CYC+2]} ||
      oe_cnt >= RESET_CYC) else $error("drive width");
  a_reset_late: assert property (
    reset_event |-> !swd_in && lo_cnt > THR_AR_CYC)
    else $error("reset flagged early");
  c_reset: cover property (reset_event);
  c_one: cover property (rsp_valid && rsp.sym == SWM_Y_ONE);
  c_start: cover property (rsp_valid && rsp.sym == SWM_Y_START);
  c_clash: cover property (rsp_valid && rsp.collide);
endmodule : swm_master_chk
bind swm_master swm_master_chk #(.LONG_CYC(LONG_CYC),
  .START_CYC(START_CYC), .RESET_CYC(RESET_CYC), .THR_OS_CYC(THR_OS_CYC),
  .THR_SA_CYC(THR_SA_CYC), .THR_AR_CYC(THR_AR_CYC)) swm_master_chk_inst (
  .sys_clk, .rst, .cmd, .cmd_valid, .cmd_ready, .rsp, .rsp_valid,
  .reset_event, .bus_idle, .swd_in, .swd_out, .swd_oe);
`default_nettype wire

// ---- testbench/swm_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
module swm_dev
  import swm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic swd,
  input  wire logic attn_now,
  input  wire logic attn_edge,
  input  wire logic stretch,
  output var  logic dev_oe
);
  // Widths are scaled to match the shortened master thresholds.
  localparam int ONE_W = 3000;
  localparam int ATT_W = 4700;
  logic prev = 1'b1;
  int   cnt = 5700;
  always @(posedge sys_clk)
  begin
    prev <= swd;
    if (cnt > 0)
      cnt <= cnt - 1;
    else if (attn_now && swd)
      cnt <= ATT_W;
    else if (prev && !swd && attn_edge)
      cnt <= ATT_W;
    else if (prev && !swd && stretch)
      cnt <= ONE_W;
  end
  assign dev_oe = cnt > 0;
endmodule : swm_dev
`default_nettype wire

// ---- testbench/swm_master_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module swm_master_tb
  import swm_pkg::*;
;
  logic     sys_clk = 1'b0;
  logic     rst = 1'b1;
  swm_cmd_t cmd = '0;
  logic     cmd_valid = 1'b0;
  logic     cmd_ready, rsp_valid, reset_event, bus_idle, swd_out, swd_oe;
  swm_rsp_t rsp;
  logic     dev_oe;
  logic     attn_now = 1'b0, attn_edge = 1'b0, stretch = 1'b0;
  wire      swd;
  int       miscompares = 0;
  int       compares = 0;
  int       rst_events = 0;
  // Shortened widths keep the order of the symbol ranges.
  localparam int unsigned TB_LONG  = 3000;
  localparam int unsigned TB_START = 4000;
  localparam int unsigned TB_RESET = 5600;
  localparam int unsigned TB_OS    = 3500;
  localparam int unsigned TB_SA    = 4500;
  localparam int unsigned TB_AR    = 5000;
  assign swd = !(swd_oe || dev_oe);
  swm_master #(.LONG_CYC(TB_LONG), .START_CYC(TB_START),
    .RESET_CYC(TB_RESET), .THR_OS_CYC(TB_OS), .THR_SA_CYC(TB_SA),
    .THR_AR_CYC(TB_AR)) swm_master_inst (
    .sys_clk, .rst, .cmd, .cmd_valid, .cmd_ready, .rsp, .rsp_valid,
    .reset_event, .bus_idle, .swd_in(swd), .swd_out, .swd_oe);
  swm_dev swm_dev_inst (.sys_clk, .swd, .attn_now, .attn_edge, .stretch,
    .dev_oe);
  always @(negedge sys_clk)
  begin
    if (reset_event === 1'b1)
    begin
      rst_events++;
    end
  end
  initial forever #5 sys_clk = ~sys_clk;
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk_rsp(input swm_rsp_t exp);
    compares++;
    if (rsp !== exp)
    begin
      miscompares++;
      $display("Error at %0t: rsp %h expected %h", $time, rsp, exp);
    end
  endtask : chk_rsp
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic chk_count(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      miscompares++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_count
  task automatic wait_ready;
    for (int n = 0; n < 20000 && cmd_ready !== 1'b1; n++)
      @(negedge sys_clk);
    if (cmd_ready !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: ready timed out", $time);
    end
  endtask : wait_ready
  task automatic wait_rsp;
    @(negedge sys_clk);
    for (int n = 0; n < 20000 && rsp_valid !== 1'b1; n++)
      @(negedge sys_clk);
    if (rsp_valid !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t: response timed out", $time);
    end
  endtask : wait_rsp
  task automatic xfer(input swm_kind_t k, input logic b, input swm_rsp_t e);
    wait_ready();
    chk_flag(bus_idle, 1'b1);
    cmd = '{k, b};
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk_flag(cmd_ready, 1'b0);
    chk_flag(bus_idle, 1'b0);
    wait_rsp();
    chk_rsp(e);
  endtask : xfer
  task automatic t_write;
    for (int i = 0; i < 14; i++)
      xfer(SWM_K_WRITE, i[0], '{i[0] ? SWM_Y_ONE : SWM_Y_ZERO, i[0], 1'b1,
        1'b0});
  endtask : t_write
  task automatic t_read;
    xfer(SWM_K_READ, 1'b0, '{SWM_Y_ZERO, 1'b0, 1'b1, 1'b0});
    stretch = 1'b1;
    xfer(SWM_K_READ, 1'b0, '{SWM_Y_ONE, 1'b1, 1'b1, 1'b0});
    stretch = 1'b0;
    xfer(SWM_K_START, 1'b0, '{SWM_Y_START, 1'b0, 1'b1, 1'b0});
  endtask : t_read
  task automatic t_attn;
    wait_ready();
    attn_now = 1'b1;
    @(negedge sys_clk);
    attn_now = 1'b0;
    wait_rsp();
    chk_rsp('{SWM_Y_ATTN, 1'b0, 1'b0, 1'b0});
    attn_edge = 1'b1;
    xfer(SWM_K_START, 1'b0, '{SWM_Y_ATTN, 1'b0, 1'b1, 1'b1});
    xfer(SWM_K_WRITE, 1'b0, '{SWM_Y_ATTN, 1'b0, 1'b1, 1'b1});
    attn_edge = 1'b0;
    xfer(SWM_K_RESET, 1'b0, '{SWM_Y_RST, 1'b0, 1'b1, 1'b0});
    chk_count(rst_events, 2);
  endtask : t_attn
  initial
  begin
    #950_000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    wait_rsp();
    chk_rsp('{SWM_Y_RST, 1'b0, 1'b1, 1'b0});
    chk_count(rst_events, 1);
    t_write();
    t_read();
    t_attn();
    give_verdict();
  end
endmodule : swm_master_tb
`default_nettype wire
